// ---- bus_write_strobe_params.svh ----
`ifndef BUS_WRITE_STROBE_PARAMS_SVH
`define BUS_WRITE_STROBE_PARAMS_SVH

// Clock periods for the strap sampling delay
`define CORE_CLK_PERIOD_NS 20
`define XTAL_PERIOD_NS 20
`define STRAP_DELAY_CYC ((`XTAL_PERIOD_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

// Bus field widths and positions
`define FULL_ADDR_W 20
`define MUX_BUS_W 16
`define ADDR_BYTE_SEL_BIT 0
`define UPPER_ZERO_MSB 19
`define UPPER_ZERO_LSB 16

// Control pin vector positions
`define PIN_BHE 0
`define PIN_WR 1
`define PIN_WHB 2
`define PIN_WLB 3
`define PIN_WB 4
`define PIN_DMA 5
`define PIN_UZI 6
`define CTRL_PIN_W 7

// Reset values of pin levels
`define CTRL_PIN_RST 7'h5f
`define ADDR_RST 20'h00000
`define MUX_RST 16'h0000

`endif

// ---- bus_write_strobe_pkg.sv ----
package bus_write_strobe_pkg;

    // Bus cycle phases, one-hot
    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_T1 = 5'h02,
        PH_T2 = 5'h04,
        PH_T3 = 5'h08,
        PH_T4 = 5'h10
    } bus_phase_t;

endpackage : bus_write_strobe_pkg

// ---- pin_driver.sv ----
`timescale 1ns/10ps

// Registered pin level plus output enable; enables drop under reset
module pin_driver #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk, // Bus clock
    input wire logic rst_b, // Async reset, active low
    input wire logic clk_en, // Freeze when low
    input wire logic [W-1:0] next_val, // Next pin level
    input wire logic [W-1:0] next_oe, // Next output enable
    output logic [W-1:0] val, // Registered pin level
    output logic [W-1:0] oe // Registered output enable
);

    // Level and enable registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            val <= RST_VAL;
            oe <= '0;
        end else if (clk_en) begin
            val <= next_val;
            oe <= next_oe;
        end
    end

endmodule : pin_driver

// ---- bus_write_strobe_logic.sv ----
`timescale 1ns/10ps
`include "bus_write_strobe_params.svh"

module bus_write_strobe_logic (
    input wire logic core_clk, // Bus clock, 50 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic clk_en, // Freeze all state when low
    input wire logic once_mode, // Emulation mode, floats the bus
    input wire logic variant_8bit, // Byte-wide data bus variant
    input wire logic hold_req, // Bus hold request
    input wire logic cyc_start, // Start a bus cycle
    input wire logic cyc_write, // Cycle writes
    input wire logic cyc_io, // Cycle targets I/O space
    input wire logic cyc_dma, // Cycle started by DMA
    input wire logic [`FULL_ADDR_W-1:0] cyc_addr, // Cycle address
    input wire logic cyc_bus_high_b, // Upper byte lane active, low
    input wire logic [`MUX_BUS_W-1:0] cyc_wdata, // Write data
    input wire logic cyc_pseudo_static_memory, // Pseudo-static cycle wanted
    input wire logic lcs_hit, // Address in lower chip-select region
    input wire logic csu_pseudo_static_memory_en, // Chip-select unit set for pseudo-static
    input wire logic bus_ready, // Ready to end the cycle
    input wire logic aden_pin_in, // Address-enable strap pin level
    output logic cyc_busy, // Bus cycle in progress
    output logic cyc_done, // Cycle ended, one pulse
    output logic hold_ack, // Bus released to hold
    output logic [`FULL_ADDR_W-1:0] full_address_bus, // Non-muxed address
    output logic full_address_oe, // Its enable
    output logic [`MUX_BUS_W-1:0] muxed_addr_data_bus, // Muxed address/data
    output logic muxed_addr_data_oe, // Its enable
    output logic bus_high_enable_b, // Bus high enable, low
    output logic bus_high_enable_oe, // Enable, shared strap pin
    output logic write_strobe_b, // Write strobe, low
    output logic write_strobe_oe, // Its enable
    output logic high_byte_write_b, // Upper lane write, low
    output logic high_byte_write_oe, // Its enable
    output logic low_byte_write_b, // Lower lane write, low
    output logic low_byte_write_oe, // Its enable
    output logic single_byte_write_enable_b, // Byte-wide write, low
    output logic single_byte_write_enable_oe, // Its enable
    output logic dma_cycle_status, // DMA cycle status
    output logic dma_cycle_status_oe, // Its enable
    output logic upper_zero_ind_b, // Upper zero indicator, low
    output logic upper_zero_ind_oe, // Its enable
    output logic status_pins_normal, // Status pins not general I/O
    output logic io_cycle, // Current cycle in I/O space
    output logic pseudo_static_memory_cycle // Current cycle pseudo-static
);

    // Cycle state
    bus_write_strobe_pkg::bus_phase_t phase, next_phase; // Bus phase
    logic cur_write, next_cur_write; // Latched write flag
    logic cur_io, next_cur_io; // Latched space
    logic cur_dma, next_cur_dma; // Latched DMA flag
    logic cur_pseudo_static_memory, next_cur_pseudo_static_memory; // Latched pseudo-static flag
    logic cur_bus_high_b, next_cur_bus_high_b; // Latched upper lane
    logic [`FULL_ADDR_W-1:0] cur_addr, next_cur_addr; // Latched address
    logic [`MUX_BUS_W-1:0] cur_wdata, next_cur_wdata; // Latched data
    logic next_hold_ack, next_cyc_busy, next_cyc_done; // Next hold, busy, done pulse

    // Strap state
    logic aden_meta, aden_sync; // Strap synchroniser
    logic [1:0] strap_cnt, next_strap_cnt; // Edges since release
    logic strap_done, next_strap_done; // Strap captured
    logic strap_normal, next_strap_normal; // Normal status pins

    // Pin next values
    logic [`CTRL_PIN_W-1:0] next_ctrl_val, next_ctrl_oe, ctrl_val, ctrl_oe;
    logic [`FULL_ADDR_W-1:0] next_addr_val, addr_oe_vec; // Address level, per-bit enables
    logic [`MUX_BUS_W-1:0] next_mux_val, mux_oe_vec; // Muxed level, per-bit enables
    logic next_addr_oe, next_mux_oe; // Next bus enables
    logic drive, in_write, in_cycle; // Bus driven, strobe window, phases one to four

    // Strap pin synchroniser, two stages; not reset, so it tracks the strap during reset
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            aden_meta <= aden_pin_in;
            aden_sync <= aden_meta;
        end
    end

    // Strap capture after reset release
    always_comb begin
        next_strap_cnt = strap_cnt;
        next_strap_done = strap_done;
        next_strap_normal = strap_normal;
        if (!strap_done) begin
            if (strap_cnt == 2'(`STRAP_DELAY_CYC)) begin
                next_strap_done = 1'b1;
                next_strap_normal = ~aden_sync;
            end else begin
                next_strap_cnt = strap_cnt + 2'h1;
            end
        end
    end

    // Strap registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            strap_normal <= 1'b0;
            status_pins_normal <= 1'b0;
        end else if (clk_en) begin
            strap_cnt <= next_strap_cnt;
            strap_done <= next_strap_done;
            strap_normal <= next_strap_normal;
            status_pins_normal <= next_strap_normal;
        end
    end

    // Phase sequencer and cycle capture
    always_comb begin
        next_phase = phase;
        next_cur_write = cur_write;
        next_cur_io = cur_io;
        next_cur_dma = cur_dma;
        next_cur_pseudo_static_memory = cur_pseudo_static_memory;
        next_cur_bus_high_b = cur_bus_high_b;
        next_cur_addr = cur_addr;
        next_cur_wdata = cur_wdata;
        next_hold_ack = hold_ack;
        next_cyc_done = 1'b0;
        unique case (phase)
            bus_write_strobe_pkg::PH_IDLE: begin
                if (hold_ack) begin // Stay released until hold drops
                    next_hold_ack = hold_req;
                end else if (hold_req) begin
                    next_hold_ack = 1'b1;
                end else if (cyc_start && strap_done && !once_mode) begin
                    next_phase = bus_write_strobe_pkg::PH_T1;
                    next_cur_write = cyc_write;
                    next_cur_io = cyc_io;
                    next_cur_dma = cyc_dma;
                    // Pseudo-static only in the lower region when enabled
                    next_cur_pseudo_static_memory = cyc_pseudo_static_memory & lcs_hit & csu_pseudo_static_memory_en & ~cyc_io;
                    next_cur_bus_high_b = variant_8bit | cyc_bus_high_b;
                    next_cur_addr = cyc_addr;
                    next_cur_wdata = cyc_wdata;
                end
            end
            bus_write_strobe_pkg::PH_T1: next_phase = bus_write_strobe_pkg::PH_T2;
            bus_write_strobe_pkg::PH_T2: next_phase = bus_write_strobe_pkg::PH_T3;
            bus_write_strobe_pkg::PH_T3: begin // Wait states until ready
                if (bus_ready) begin
                    next_phase = bus_write_strobe_pkg::PH_T4;
                end
            end
            bus_write_strobe_pkg::PH_T4: begin
                next_phase = bus_write_strobe_pkg::PH_IDLE;
                next_cyc_done = 1'b1;
            end
        endcase
        next_cyc_busy = next_phase != bus_write_strobe_pkg::PH_IDLE;
    end

    // Cycle registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= bus_write_strobe_pkg::PH_IDLE;
            cur_write <= 1'b0;
            cur_io <= 1'b0;
            cur_dma <= 1'b0;
            cur_pseudo_static_memory <= 1'b0;
            cur_bus_high_b <= 1'b1;
            cur_addr <= `ADDR_RST;
            cur_wdata <= `MUX_RST;
            hold_ack <= 1'b0;
            cyc_busy <= 1'b0;
            cyc_done <= 1'b0;
            io_cycle <= 1'b0;
            pseudo_static_memory_cycle <= 1'b0;
        end else if (clk_en) begin
            phase <= next_phase;
            cur_write <= next_cur_write;
            cur_io <= next_cur_io;
            cur_dma <= next_cur_dma;
            cur_pseudo_static_memory <= next_cur_pseudo_static_memory;
            cur_bus_high_b <= next_cur_bus_high_b;
            cur_addr <= next_cur_addr;
            cur_wdata <= next_cur_wdata;
            hold_ack <= next_hold_ack;
            cyc_busy <= next_cyc_busy;
            cyc_done <= next_cyc_done;
            io_cycle <= next_cur_io & next_cyc_busy;
            pseudo_static_memory_cycle <= next_cur_pseudo_static_memory & next_cyc_busy;
        end
    end

    // Pin levels for the phase about to be shown
    always_comb begin
        drive = strap_done & ~next_hold_ack & ~once_mode;
        in_cycle = next_phase != bus_write_strobe_pkg::PH_IDLE;
        in_write = next_cur_write & (next_phase == bus_write_strobe_pkg::PH_T2
            || next_phase == bus_write_strobe_pkg::PH_T3);
        next_addr_val = in_cycle ? next_cur_addr : `ADDR_RST; // Held T1 to T4
        next_addr_oe = drive;
        // Muxed bus: address in T1, write data later, off for reads
        next_mux_val = `MUX_RST;
        next_mux_oe = 1'b0;
        if (next_phase == bus_write_strobe_pkg::PH_T1) begin
            next_mux_val = next_cur_addr[`MUX_BUS_W-1:0];
            next_mux_oe = drive;
        end else if (in_cycle && next_cur_write) begin
            next_mux_val = next_cur_wdata;
            next_mux_oe = drive;
        end
        next_ctrl_val = `CTRL_PIN_RST;
        next_ctrl_val[`PIN_BHE] = in_cycle ? next_cur_bus_high_b : 1'b1;
        next_ctrl_val[`PIN_WR] = ~in_write;
        // Byte enables registered on the same edge as the address
        next_ctrl_val[`PIN_WHB] = next_ctrl_val[`PIN_BHE] | ~in_write;
        next_ctrl_val[`PIN_WLB] = next_cur_addr[`ADDR_BYTE_SEL_BIT] | ~in_write;
        next_ctrl_val[`PIN_WB] = ~in_write;
        next_ctrl_val[`PIN_DMA] = next_cur_dma & in_cycle
            & (next_phase != bus_write_strobe_pkg::PH_T1);
        next_ctrl_val[`PIN_UZI] = in_cycle
            ? |(~next_cur_addr[`UPPER_ZERO_MSB:`UPPER_ZERO_LSB]) : 1'b1;
        next_ctrl_oe = '0;
        next_ctrl_oe[`PIN_BHE] = drive & ~variant_8bit; // Strap pin floats in hold
        next_ctrl_oe[`PIN_WR] = drive;
        next_ctrl_oe[`PIN_WHB] = strap_done & ~variant_8bit & ~once_mode;
        next_ctrl_oe[`PIN_WLB] = strap_done & ~variant_8bit & ~once_mode;
        next_ctrl_oe[`PIN_WB] = strap_done & variant_8bit & ~once_mode;
        next_ctrl_oe[`PIN_DMA] = drive & next_strap_normal;
        next_ctrl_oe[`PIN_UZI] = strap_done & ~once_mode & next_strap_normal;
    end

    // Full address pins
    pin_driver #(.W(`FULL_ADDR_W), .RST_VAL(`ADDR_RST)) u_addr_pins (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .next_val(next_addr_val),
        .next_oe({`FULL_ADDR_W{next_addr_oe}}),
        .val(full_address_bus),
        .oe(addr_oe_vec)
    );

    // Muxed address/data pins
    pin_driver #(.W(`MUX_BUS_W), .RST_VAL(`MUX_RST)) u_mux_pins (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .next_val(next_mux_val),
        .next_oe({`MUX_BUS_W{next_mux_oe}}),
        .val(muxed_addr_data_bus),
        .oe(mux_oe_vec)
    );

    // Strobe and status pins
    pin_driver #(.W(`CTRL_PIN_W), .RST_VAL(`CTRL_PIN_RST)) u_ctrl_pins (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .next_val(next_ctrl_val),
        .next_oe(next_ctrl_oe),
        .val(ctrl_val),
        .oe(ctrl_oe)
    );

    // Flop outputs fanned to ports
    assign full_address_oe = addr_oe_vec[0];
    assign muxed_addr_data_oe = mux_oe_vec[0];
    assign bus_high_enable_b = ctrl_val[`PIN_BHE];
    assign bus_high_enable_oe = ctrl_oe[`PIN_BHE];
    assign write_strobe_b = ctrl_val[`PIN_WR];
    assign write_strobe_oe = ctrl_oe[`PIN_WR];
    assign high_byte_write_b = ctrl_val[`PIN_WHB];
    assign high_byte_write_oe = ctrl_oe[`PIN_WHB];
    assign low_byte_write_b = ctrl_val[`PIN_WLB];
    assign low_byte_write_oe = ctrl_oe[`PIN_WLB];
    assign single_byte_write_enable_b = ctrl_val[`PIN_WB];
    assign single_byte_write_enable_oe = ctrl_oe[`PIN_WB];
    assign dma_cycle_status = ctrl_val[`PIN_DMA];
    assign dma_cycle_status_oe = ctrl_oe[`PIN_DMA];
    assign upper_zero_ind_b = ctrl_val[`PIN_UZI];
    assign upper_zero_ind_oe = ctrl_oe[`PIN_UZI];

endmodule : bus_write_strobe_logic

// ---- bus_write_strobe_monitor.sv ----
`timescale 1ns/10ps

// Port-level checks on strobes, enables and bus phases
module bus_write_strobe_monitor (
    input wire logic core_clk, // Bus clock
    input wire logic rst_b, // Reset, low
    input wire logic once_mode, // Emulation mode
    input wire logic variant_8bit, // Byte-wide variant
    input wire logic cyc_busy, // Cycle active
    input wire logic cyc_done, // Cycle end pulse
    input wire logic hold_ack, // Bus held
    input wire logic [19:0] full_address_bus, // Address
    input wire logic full_address_oe, // Its enable
    input wire logic [15:0] muxed_addr_data_bus, // Muxed bus
    input wire logic muxed_addr_data_oe, // Its enable
    input wire logic bus_high_enable_b, // Bus high, low
    input wire logic write_strobe_b, // Strobe, low
    input wire logic write_strobe_oe, // Its enable
    input wire logic high_byte_write_b, // Upper lane, low
    input wire logic low_byte_write_b, // Lower lane, low
    input wire logic single_byte_write_enable_b // Byte-wide, low
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_high_byte_or: assert property (cyc_busy && !variant_8bit |->
        high_byte_write_b == (bus_high_enable_b | write_strobe_b)) else $error("whb mismatch");
    a_low_byte_or: assert property (cyc_busy && !variant_8bit |->
        low_byte_write_b == (full_address_bus[0] | write_strobe_b)) else $error("wlb mismatch");
    a_single_byte: assert property (cyc_busy && variant_8bit |->
        single_byte_write_enable_b == write_strobe_b) else $error("wb mismatch");
    a_idle_strobe_high: assert property (!cyc_busy && write_strobe_oe |->
        write_strobe_b) else $error("strobe low outside cycle");
    a_hold_float: assert property (hold_ack |-> !write_strobe_oe && !full_address_oe)
        else $error("driven in hold");
    a_once_float: assert property (once_mode |=> !write_strobe_oe && !full_address_oe)
        else $error("driven in emulation mode");
    a_addr_stable: assert property (cyc_busy && $past(cyc_busy) |->
        $stable(full_address_bus)) else $error("address moved in cycle");
    a_mux_first: assert property ($rose(cyc_busy) |-> muxed_addr_data_oe &&
        muxed_addr_data_bus == full_address_bus[15:0]) else $error("no address in T1");
    a_strobe_end: assert property ($rose(write_strobe_b) |-> cyc_busy ##1 cyc_done)
        else $error("strobe end off T4");
    a_busy_min: assert property ($rose(cyc_busy) |-> cyc_busy [*4])
        else $error("cycle shorter than four phases");
endmodule : bus_write_strobe_monitor

bind bus_write_strobe_logic bus_write_strobe_monitor mon (.*);

// ---- sram_model.sv ----
`timescale 1ns/10ps

// Byte-lane memory and ready source on the local bus
module sram_model (
    input wire logic core_clk, // Bus clock
    input wire logic cyc_busy, // Cycle active
    input wire logic wide, // Wired to both lanes
    input wire logic [19:0] addr, // Full address
    input wire logic [15:0] data, // Muxed bus
    input wire logic whb_b, // Upper lane write, low
    input wire logic wlb_b, // Lower lane write, low
    input wire logic wb_b, // Byte-wide write, low
    input wire logic [3:0] waits, // Extra T3 cycles
    output logic bus_ready // Ends T3
);
    logic [7:0] mem [0:255]; // Byte store
    logic [3:0] cnt; // Cycles into the bus cycle

    // Lanes stored with the address of the same edge
    always_ff @(posedge core_clk) begin
        cnt <= cyc_busy ? cnt + 4'h1 : 4'h0;
        if (wide && !whb_b) mem[{addr[7:1], 1'b1}] <= data[15:8];
        if (wide && !wlb_b) mem[addr[7:0]] <= data[7:0];
        if (!wide && !wb_b) mem[addr[7:0]] <= data[7:0];
    end

    // Ready from T3 on, after the wanted waits
    assign bus_ready = cyc_busy && (cnt >= 4'h2 + waits);
endmodule : sram_model

// ---- testbench.sv ----
`timescale 1ns/10ps

// Directed scenarios for the write strobe block
module testbench;
    logic core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, once_mode = 1'b0, variant_8bit = 1'b0;
    logic hold_req = 1'b0, cyc_start = 1'b0, cyc_write = 1'b0, cyc_io = 1'b0, cyc_dma = 1'b0;
    logic [19:0] cyc_addr = 20'h00000; // Cycle address
    logic [15:0] cyc_wdata = 16'h0000; // Write data
    logic cyc_bus_high_b = 1'b1, cyc_pseudo_static_memory = 1'b0, lcs_hit = 1'b0, csu_pseudo_static_memory_en = 1'b0;
    logic bus_ready, aden_pin_in = 1'b1;
    logic cyc_busy, cyc_done, hold_ack, full_address_oe, muxed_addr_data_oe;
    logic [19:0] full_address_bus; // Address pins
    logic [15:0] muxed_addr_data_bus; // Muxed pins
    logic bus_high_enable_b, bus_high_enable_oe, write_strobe_b, write_strobe_oe;
    logic high_byte_write_b, high_byte_write_oe, low_byte_write_b, low_byte_write_oe;
    logic single_byte_write_enable_b, single_byte_write_enable_oe, dma_cycle_status;
    logic dma_cycle_status_oe, upper_zero_ind_b, upper_zero_ind_oe, status_pins_normal;
    logic io_cycle, pseudo_static_memory_cycle, seen_dma, seen_io, seen_ps, seen_uz;
    logic [3:0] waits = 4'h0; // Partner ready delay
    int err_count = 0, num_checks = 0, n_low;

    always #10 core_clk = ~core_clk;

    bus_write_strobe_logic dut (.*);
    sram_model sram (.core_clk, .cyc_busy, .wide(~variant_8bit), .addr(full_address_bus),
        .data(muxed_addr_data_bus), .whb_b(high_byte_write_b), .wlb_b(low_byte_write_b),
        .wb_b(single_byte_write_enable_b), .waits, .bus_ready);

    // Verdict and end of run
    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Compare one value
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check

    // Step to just after the next edge
    task automatic tick();
        @(posedge core_clk);
        #2;
    endtask : tick

    // Reset with a strap level and variant
    task automatic do_reset(input logic aden, input logic v8);
        rst_b = 1'b0;
        aden_pin_in = aden;
        variant_8bit = v8;
        repeat (6) tick();
        check("strobe oe", 8'h00, write_strobe_oe);
        check("whb oe", 8'h00, high_byte_write_oe);
        check("wlb oe", 8'h00, low_byte_write_oe);
        check("wb oe", 8'h00, single_byte_write_enable_oe);
        rst_b = 1'b1;
        repeat (4) tick();
        check("status normal", {7'h00, ~aden}, status_pins_normal);
        check("dma oe", {7'h00, ~aden}, dma_cycle_status_oe);
        check("uzi oe", {7'h00, ~aden}, upper_zero_ind_oe);
        check("bhe oe", {7'h00, ~v8}, bus_high_enable_oe);
        check("whb oe on", {7'h00, ~v8}, high_byte_write_oe);
        check("wb oe on", {7'h00, v8}, single_byte_write_enable_oe);
    endtask : do_reset

    // One bus cycle, watched until done
    task automatic run_cycle(input logic w, input logic [19:0] a, input logic bh,
            input logic [15:0] d);
        int i;
        cyc_start = 1'b1;
        cyc_write = w;
        cyc_addr = a;
        cyc_bus_high_b = bh;
        cyc_wdata = d;
        tick();
        cyc_start = 1'b0;
        n_low = 0;
        seen_dma = 1'b0;
        seen_io = 1'b0;
        seen_ps = 1'b0;
        seen_uz = 1'b0;
        for (i = 0; i < 40 && cyc_done !== 1'b1; i++) begin
            n_low += (write_strobe_b === 1'b0);
            seen_dma |= (dma_cycle_status === 1'b1);
            seen_io |= (io_cycle === 1'b1);
            seen_ps |= (pseudo_static_memory_cycle === 1'b1);
            seen_uz |= (upper_zero_ind_b === 1'b0);
            tick();
        end
        if (i == 40) begin
            err_count++;
            print_verdict();
        end
    endtask : run_cycle

    // Word, upper and lower lane writes back to back
    task automatic t_lanes();
        logic [19:0] a [3] = '{20'h00010, 20'h00011, 20'h00010};
        logic [15:0] d [3] = '{16'h1234, 16'hab00, 16'h0056};
        logic bh [3] = '{1'b0, 1'b0, 1'b1};
        logic [7:0] lo [3] = '{8'h34, 8'h34, 8'h56};
        logic [7:0] hi [3] = '{8'h12, 8'hab, 8'hab};
        for (int k = 0; k < 3; k++) begin
            run_cycle(1'b1, a[k], bh[k], d[k]);
            check("low lane", lo[k], sram.mem[8'h10]);
            check("high lane", hi[k], sram.mem[8'h11]);
            check("strobe cycles", 8'h02, n_low[7:0]);
        end
    endtask : t_lanes

    // Read leaves strobe high and memory alone
    task automatic t_read();
        run_cycle(1'b0, 20'h00010, 1'b0, 16'hffff);
        check("read strobe", 8'h00, n_low[7:0]);
        check("read keeps", 8'h56, sram.mem[8'h10]);
        check("read uzi", 8'h00, seen_uz);
    endtask : t_read

    // Slow memory stretches the strobe
    task automatic t_waits();
        waits = 4'h3;
        run_cycle(1'b1, 20'hf0020, 1'b0, 16'h5a5a);
        check("wait strobe", 8'h05, n_low[7:0]);
        check("wait data", 8'h5a, sram.mem[8'h21]);
        check("upper zero", 8'h01, seen_uz);
        waits = 4'h0;
    endtask : t_waits

    // Space, pseudo-static and DMA attributes
    task automatic t_attrs();
        logic [4:0] cfg [4] = '{5'h10, 5'h0f, 5'h0d, 5'h1e};
        for (int k = 0; k < 4; k++) begin
            {cyc_io, cyc_pseudo_static_memory, lcs_hit, csu_pseudo_static_memory_en, cyc_dma} = cfg[k];
            run_cycle(1'b1, 20'h00040, 1'b0, 16'h0000);
            check("io cycle", {7'h00, cfg[k][4]}, seen_io);
            check("pseudo_static_memory", {7'h00, &cfg[k][3:1] & ~cfg[k][4]}, seen_ps);
            check("dma status", {7'h00, cfg[k][0]}, seen_dma);
        end
        {cyc_io, cyc_pseudo_static_memory, lcs_hit, csu_pseudo_static_memory_en, cyc_dma} = 5'h00;
    endtask : t_attrs

    // Hold floats the strobe and refuses starts
    task automatic t_hold();
        hold_req = 1'b1;
        tick();
        cyc_start = 1'b1;
        tick();
        check("hold ack", 8'h01, hold_ack);
        check("hold strobe oe", 8'h00, write_strobe_oe);
        check("hold bhe oe", 8'h00, bus_high_enable_oe);
        check("held busy", 8'h00, cyc_busy);
        cyc_start = 1'b0;
        hold_req = 1'b0;
        repeat (2) tick();
        check("hold end", 8'h00, hold_ack);
    endtask : t_hold

    // Emulation mode floats the pins
    task automatic t_once();
        once_mode = 1'b1;
        repeat (2) tick();
        check("once strobe oe", 8'h00, write_strobe_oe);
        check("once addr oe", 8'h00, full_address_oe);
        once_mode = 1'b0;
    endtask : t_once

    // Byte-wide variant uses the single enable
    task automatic t_8bit();
        do_reset(1'b0, 1'b1);
        run_cycle(1'b1, 20'h00031, 1'b1, 16'h00c3);
        check("byte write", 8'hc3, sram.mem[8'h31]);
        check("byte strobe", 8'h02, n_low[7:0]);
    endtask : t_8bit

    // Clock enable low freezes a write in its strobe window
    task automatic t_freeze();
        cyc_start = 1'b1;
        cyc_write = 1'b1;
        cyc_addr = 20'h00060;
        cyc_bus_high_b = 1'b0;
        cyc_wdata = 16'h7788;
        tick();
        cyc_start = 1'b0;
        tick();
        clk_en = 1'b0;
        repeat (3) tick();
        check("frozen strobe", 8'h00, write_strobe_b);
        check("frozen busy", 8'h01, cyc_busy);
        check("frozen address", 8'h60, full_address_bus[7:0]);
        clk_en = 1'b1;
        repeat (3) tick();
        check("thaw done", 8'h01, cyc_done);
        check("thaw low lane", 8'h88, sram.mem[8'h60]);
        check("thaw high lane", 8'h77, sram.mem[8'h61]);
    endtask : t_freeze

    // Main sequence
    initial begin
        do_reset(1'b1, 1'b0);
        do_reset(1'b0, 1'b0);
        t_lanes();
        t_read();
        t_waits();
        t_attrs();
        t_freeze();
        t_hold();
        t_once();
        t_8bit();
        print_verdict();
    end
endmodule : testbench
